// file: src/capc_cfg.svh
// Constants of the command/address parity checker
`ifndef CAPC_CFG_SVH
`define CAPC_CFG_SVH

// Clock period and timing figures in ns
`define CAPC_CLK_NS      40
`define CAPC_ALERT_ON_NS 80
`define CAPC_PW_MIN_NS   2000
`define CAPC_PW_MAX_NS   4000
`define CAPC_RAS_MIN_NS  32

// Parity latency field codes and their clock counts
`define CAPC_LAT_OFF     3'h0
`define CAPC_LAT_4       3'h1
`define CAPC_LAT_5       3'h2
`define CAPC_LAT_6       3'h3
`define CAPC_LAT_8       3'h4
`define CAPC_CLK_4       4'h4
`define CAPC_CLK_5       4'h5
`define CAPC_CLK_6       4'h6
`define CAPC_CLK_8       4'h8

// Widths and reset values
`define CAPC_DEPTH       8
`define CAPC_CMD_W       26
`define CAPC_CNT_W       8
`define CAPC_ADDR_MASK   18'h3ffff
`define CAPC_STACK_MASK  3'h0
`define CAPC_LAT_RST     3'h0

`endif

// file: src/capc_checker.sv
// Command/address parity checker: check, hold, error handling and alert
`timescale 1ns/1ps
`include "capc_cfg.svh"
module capc_checker (
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	// Command bus
	input  wire logic        cs_n_i,
	input  wire logic        act_n_i,
	input  wire logic [17:0] addr_i,
	input  wire logic [1:0]  bg_i,
	input  wire logic [1:0]  ba_i,
	input  wire logic [2:0]  cid_i,
	input  wire logic        par_i,
	// Parity mode register write
	input  wire logic        pmr_wr_i,
	input  wire logic [2:0]  pmr_lat_i,
	input  wire logic        pmr_status_i,
	input  wire logic        pmr_persist_i,
	// Core feedback
	input  wire logic        banks_closed_i,
	// Command to execute
	output logic             exec_valid_o,
	output logic             exec_act_n_o,
	output logic [17:0]      exec_addr_o,
	output logic [1:0]       exec_bg_o,
	output logic [1:0]       exec_ba_o,
	output logic [2:0]       exec_cid_o,
	// Error handling
	output logic             alert_n_o,
	output logic             par_status_o,
	output logic             prech_all_o,
	output logic             dqs_quiet_o,
	// Error log
	output logic             log_act_n_o,
	output logic [17:0]      log_addr_o,
	output logic [1:0]       log_bg_o,
	output logic [1:0]       log_ba_o,
	output logic [2:0]       log_cid_o,
	output logic             log_par_o
);
	import capc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Cycle counts; least times round up, longest round down, never below one
	localparam int ON_I  = `CAPC_ALERT_ON_NS / `CAPC_CLK_NS;
	localparam int ON_CYC = (ON_I < 1) ? 1 : ON_I;
	localparam int MIN_I = (`CAPC_PW_MIN_NS + `CAPC_CLK_NS - 1) / `CAPC_CLK_NS;
	localparam int MAX_I = `CAPC_PW_MAX_NS / `CAPC_CLK_NS;
	localparam int RAS_I = (`CAPC_RAS_MIN_NS + `CAPC_CLK_NS - 1) / `CAPC_CLK_NS;
	localparam logic [`CAPC_CNT_W-1:0] PW_MIN_CYC = `CAPC_CNT_W'((MIN_I < 1) ? 1 : MIN_I);
	localparam logic [`CAPC_CNT_W-1:0] PW_MAX_CYC = `CAPC_CNT_W'((MAX_I < 1) ? 1 : MAX_I);
	localparam logic [`CAPC_CNT_W-1:0] RAS_CYC    = `CAPC_CNT_W'((RAS_I < 1) ? 1 : RAS_I);

	function automatic logic [3:0] lat_clocks(logic [2:0] code);
		logic [3:0] n;
		n = 4'h0;
		case (code)
			`CAPC_LAT_4: n = `CAPC_CLK_4;
			`CAPC_LAT_5: n = `CAPC_CLK_5;
			`CAPC_LAT_6: n = `CAPC_CLK_6;
			`CAPC_LAT_8: n = `CAPC_CLK_8;
			default:     n = 4'h0;
		endcase
		return n;
	endfunction

	// Odd result means the frame, stack id masked off, plus parity bit holds an odd count of ones
	function automatic logic frame_odd(capc_cmd_t c, logic p);
		return ^{c.act_n, c.addr & `CAPC_ADDR_MASK, c.bg, c.ba, c.cid & `CAPC_STACK_MASK, p};
	endfunction

	capc_core_t q;
	capc_core_t d;
	capc_cmd_t  cmd;
	capc_cmd_t  exec_cmd;
	logic [3:0] lat_n;
	logic       par_en;
	logic       busy;
	logic       sel;
	logic       check_on;
	logic       err;
	logic       push;
	logic [2:0] tap;

	////////////////////////////////////////////////////////////////////////
	// Capture and check; parity is taken from the same edge as the frame
	always_comb
	begin
		cmd      = capc_cmd_t'({act_n_i, addr_i, bg_i, ba_i, cid_i});
		lat_n    = lat_clocks(q.lat);
		par_en   = (lat_n != 4'h0);
		busy     = (q.st != CAPC_IDLE);
		sel      = !cs_n_i;
		// Persistent mode checks again once the alert is released and the sequence is back in idle
		check_on = par_en && (!q.status || (q.persist && q.alert_n));
		err      = sel && check_on && !busy && frame_odd(cmd, par_i);
		// Commands arriving during the alert window are not executed
		push     = sel && !busy && !err;
		tap      = par_en ? 3'(lat_n - 4'h1) : 3'h0;
	end

	capc_hold_line u_line (
		.mclk_i       (mclk_i),
		.reset_i      (reset_i),
		.push_i       (push),
		.cmd_i        (cmd),
		.flush_i      (err),
		.tap_i        (tap),
		.exec_valid_o (exec_valid_o),
		.exec_cmd_o   (exec_cmd)
	);

	////////////////////////////////////////////////////////////////////////
	// Error sequence
	always_comb
	begin
		d       = q;
		d.prech = 1'b0;
		if (busy && (q.cnt != '1))
			d.cnt = q.cnt + `CAPC_CNT_W'(1);
		if (pmr_wr_i)
		begin
			d.lat     = pmr_lat_i;
			d.persist = pmr_persist_i;
			// A write of one is ignored
			if (!pmr_status_i)
				d.status = 1'b0;
		end
		case (q.st)
			CAPC_IDLE:
			begin
				if (err)
				begin
					d.st      = CAPC_RAS;
					d.cnt     = '0;
					d.alert_n = 1'b0;
					// Set wins over a clear written in the same cycle
					d.status  = 1'b1;
					d.log_cmd = cmd;
					d.log_par = par_i;
				end
			end
			CAPC_RAS:
			begin
				// Row-active minimum runs from the error, not per bank
				if (q.cnt >= RAS_CYC)
				begin
					d.st    = CAPC_CLOSE;
					d.prech = 1'b1;
				end
			end
			CAPC_CLOSE:
			begin
				if ((q.cnt >= PW_MIN_CYC) && banks_closed_i && !q.prech)
				begin
					d.alert_n = 1'b1;
					d.st      = CAPC_HOLD;
				end
			end
			CAPC_HOLD:
			begin
				if (q.cnt >= PW_MAX_CYC)
					d.st = CAPC_IDLE;
			end
			default:
				d.st = CAPC_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			q         <= '0;
			q.st      <= CAPC_IDLE;
			q.alert_n <= 1'b1;
			q.lat     <= `CAPC_LAT_RST;
		end
		else
			q <= d;
	end

	////////////////////////////////////////////////////////////////////////
	assign exec_act_n_o = exec_cmd.act_n;
	assign exec_addr_o  = exec_cmd.addr;
	assign exec_bg_o    = exec_cmd.bg;
	assign exec_ba_o    = exec_cmd.ba;
	assign exec_cid_o   = exec_cmd.cid;
	assign alert_n_o    = q.alert_n;
	assign par_status_o = q.status;
	assign prech_all_o  = q.prech;
	// No read is issued while busy, so the strobes stay idle
	assign dqs_quiet_o  = busy;
	assign log_act_n_o  = q.log_cmd.act_n;
	assign log_addr_o   = q.log_cmd.addr;
	assign log_bg_o     = q.log_cmd.bg;
	assign log_ba_o     = q.log_cmd.ba;
	assign log_cid_o    = q.log_cmd.cid;
	assign log_par_o    = q.log_par;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	sequence take_four_s;
		push && !err && (lat_n == `CAPC_CLK_4);
	endsequence
	sequence no_flush_s;
		(!err)[*3];
	endsequence

	hold_four_a: assert property (take_four_s ##1 no_flush_s |=> exec_valid_o)
		else $error("command not executed after four clocks");
	alert_on_a: assert property (err |-> ##[1:ON_CYC] !alert_n_o)
		else $error("alert not asserted in time");
	status_set_a: assert property (err |=> par_status_o && !alert_n_o)
		else $error("status bit not set on error");
	drop_fail_a: assert property (err |=> (!exec_valid_o)[*8])
		else $error("command executed after parity error");
	no_exec_a: assert property (busy |-> !exec_valid_o && dqs_quiet_o)
		else $error("command executed in alert window");
	release_a: assert property ($rose(alert_n_o) |-> $past(banks_closed_i) && ($past(q.cnt) >= PW_MIN_CYC))
		else $error("alert released too early");
	prech_wait_a: assert property ($rose(prech_all_o) |-> q.cnt > RAS_CYC)
		else $error("precharge before row-active minimum");
	resume_a: assert property ($fell(busy) |-> $past(q.cnt) >= PW_MAX_CYC)
		else $error("commands resumed before pulse maximum");
	log_keep_a: assert property (err |=> log_addr_o == $past(addr_i) && log_par_o == $past(par_i))
		else $error("error log not loaded");
	clear_only_a: assert property (pmr_wr_i && pmr_status_i && !q.status && !err |=> !par_status_o)
		else $error("status bit written to one");
	no_check_a: assert property (q.status && !q.persist && sel |-> !err)
		else $error("checking while status set");
	persist_a: assert property (q.persist && q.alert_n && par_en && sel && !busy && frame_odd(cmd, par_i) |-> err)
		else $error("persistent mode missed an error");

endmodule

// file: src/capc_hold_line.sv
// Command hold line: delays accepted commands by a selectable number of clocks
`timescale 1ns/1ps
`include "capc_cfg.svh"
module capc_hold_line (
	// Clock and reset
	input  wire logic                   mclk_i,
	input  wire logic                   reset_i,
	// Command entry
	input  wire logic                   push_i,
	input  wire logic [`CAPC_CMD_W-1:0] cmd_i,
	input  wire logic                   flush_i,
	input  wire logic [2:0]             tap_i,
	// Command to execute
	output logic                        exec_valid_o,
	output logic [`CAPC_CMD_W-1:0]      exec_cmd_o
);
	import capc_pkg::*;

	capc_line_t q;
	capc_line_t d;

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		d = q;
		if (flush_i)
		begin
			// Pending commands fall in the uncertain window and are dropped
			d.vld = '0;
		end
		else
		begin
			d.vld = {q.vld[`CAPC_DEPTH-2:0], push_i};
			d.cmd = {q.cmd[`CAPC_DEPTH-2:0], cmd_i};
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
			q <= '0;
		else
			q <= d;
	end

	// Tap n-1 means the command waited n clocks before execution
	assign exec_valid_o = q.vld[tap_i];
	assign exec_cmd_o   = q.cmd[tap_i];

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	flush_empties_a: assert property (flush_i |=> !exec_valid_o)
		else $error("command executed right after flush");

endmodule

// file: src/capc_pkg.sv
// Types of the command/address parity checker
package capc_pkg;
`include "capc_cfg.svh"

	typedef enum logic [1:0] {CAPC_IDLE, CAPC_RAS, CAPC_CLOSE, CAPC_HOLD} capc_state_t;

	typedef struct packed {
		logic        act_n;
		logic [17:0] addr;
		logic [1:0]  bg;
		logic [1:0]  ba;
		logic [2:0]  cid;
	} capc_cmd_t;

	typedef struct packed {
		capc_state_t            st;
		logic [`CAPC_CNT_W-1:0] cnt;
		logic                   alert_n;
		logic                   status;
		logic                   persist;
		logic [2:0]             lat;
		capc_cmd_t              log_cmd;
		logic                   log_par;
		logic                   prech;
	} capc_core_t;

	typedef struct packed {
		logic [`CAPC_DEPTH-1:0]                 vld;
		logic [`CAPC_DEPTH-1:0][`CAPC_CMD_W-1:0] cmd;
	} capc_line_t;

endpackage

// file: test/capc_ctrl_model.sv
// Controller model: drives commands and parity mode register writes
`timescale 1ns/1ps
module capc_ctrl_model (
	// Clock
	input  wire logic        mclk_i,
	// Command bus
	output logic             cs_n_o,
	output logic             act_n_o,
	output logic [17:0]      addr_o,
	output logic [1:0]       bg_o,
	output logic [1:0]       ba_o,
	output logic [2:0]       cid_o,
	output logic             par_o,
	// Mode register write
	output logic             pmr_wr_o,
	output logic [2:0]       pmr_lat_o,
	output logic             pmr_status_o,
	output logic             pmr_persist_o
);
	import capc_pkg::*;

	initial {cs_n_o, pmr_wr_o} = 2'h2;
	initial {act_n_o, addr_o, bg_o, ba_o, cid_o, par_o, pmr_lat_o, pmr_status_o, pmr_persist_o} = '0;

	////////////////////////////////////////////////////////////////////////
	// One selected cycle; bad flips the parity bit on purpose
	task automatic send(input capc_cmd_t c, input logic bad);
		@(posedge mclk_i);
		cs_n_o <= 1'b0;
		{act_n_o, addr_o, bg_o, ba_o, cid_o} <= c;
		// Stack id left out: a monolithic part counts those pins as zero
		par_o <= ^{c.act_n, c.addr, c.bg, c.ba} ^ bad;
		@(posedge mclk_i);
		cs_n_o <= 1'b1;
		// Released lines flip; with 24 checked bits flipped, a stale frame keeps its parity
		{act_n_o, addr_o, bg_o, ba_o, cid_o, par_o} <= ~{act_n_o, addr_o, bg_o, ba_o, cid_o, par_o};
	endtask

	// The bus runs in 1N command mode only, so odd latency codes are legal
	// Power-saving entry is never requested, so parity need not be dropped first
	task automatic mrw(input logic [2:0] lat, input logic st, input logic per);
		@(posedge mclk_i);
		{pmr_wr_o, pmr_lat_o, pmr_status_o, pmr_persist_o} <= {1'b1, lat, st, per};
		@(posedge mclk_i);
		pmr_wr_o <= 1'b0;
	endtask
endmodule

// file: test/tb.sv
// Self-checking bench of the command/address parity checker
`timescale 1ns/1ps
module tb;
	import capc_pkg::*;

	localparam capc_cmd_t C1 = capc_cmd_t'(26'h1a5c3e9);
	localparam capc_cmd_t C2 = capc_cmd_t'(26'h2c3a5d6);
	logic        mclk_i, reset_i, banks_closed_i, cs_n_i, act_n_i, par_i;
	logic        pmr_wr_i, pmr_status_i, pmr_persist_i, exec_valid_o, exec_act_n_o;
	logic        alert_n_o, par_status_o, prech_all_o, dqs_quiet_o, log_act_n_o, log_par_o;
	logic [17:0] addr_i, exec_addr_o, log_addr_o;
	logic [1:0]  bg_i, ba_i, exec_bg_o, exec_ba_o, log_bg_o, log_ba_o;
	logic [2:0]  cid_i, pmr_lat_i, exec_cid_o, log_cid_o;
	int          n_mismatch, checks_done;

	capc_ctrl_model ctl (.mclk_i, .cs_n_o(cs_n_i), .act_n_o(act_n_i), .addr_o(addr_i), .bg_o(bg_i), .ba_o(ba_i),
		.cid_o(cid_i), .par_o(par_i), .pmr_wr_o(pmr_wr_i), .pmr_lat_o(pmr_lat_i), .pmr_status_o(pmr_status_i),
		.pmr_persist_o(pmr_persist_i));
	capc_checker DUT (.mclk_i, .reset_i, .cs_n_i, .act_n_i, .addr_i, .bg_i, .ba_i, .cid_i, .par_i, .pmr_wr_i,
		.pmr_lat_i, .pmr_status_i, .pmr_persist_i, .banks_closed_i, .exec_valid_o, .exec_act_n_o, .exec_addr_o,
		.exec_bg_o, .exec_ba_o, .exec_cid_o, .alert_n_o, .par_status_o, .prech_all_o, .dqs_quiet_o, .log_act_n_o,
		.log_addr_o, .log_bg_o, .log_ba_o, .log_cid_o, .log_par_o);

	////////////////////////////////////////////////////////////////////////
	// Wide enough for the error log with its parity bit
	task automatic chk(input string nm, input logic [26:0] e, input logic [26:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic report_and_stop();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Cycles counted from the cycle the frame is on the bus
	task automatic cmd_ok(input capc_cmd_t c, input logic bad, input int n);
		int k = 1;
		ctl.send(c, bad);
		#1;
		while (exec_valid_o !== 1'b1 && k < 12)
		begin
			@(posedge mclk_i);
			#1;
			k++;
		end
		chk("latency", 26'(n), 26'(k));
		chk("exec", c, {exec_act_n_o, exec_addr_o, exec_bg_o, exec_ba_o, exec_cid_o});
	endtask

	// Every latency code, reserved ones too; bad parity is harmless while off
	task automatic s_latency();
		int lat_clk [8] = '{1, 4, 5, 6, 8, 1, 1, 1};
		for (int i = 0; i < 8; i++)
		begin
			ctl.mrw(3'h0, 1'b1, 1'b0);
			ctl.mrw(i[2:0], 1'b1, 1'b0);
			cmd_ok(capc_cmd_t'({i[0], 18'h2a5c3 ^ 18'(i), 7'h4d}), i == 0 || i > 4, lat_clk[i]);
			chk("status", 1'b0, par_status_o);
		end
	endtask

	// Error sequence; lead puts a good command in the hold line first
	task automatic err_run(input capc_cmd_t c, input logic lead);
		int ra = 0;
		int rq = 0;
		int np = 0;
		int ne = 0;
		// Core feedback changes only on a rising edge
		@(posedge mclk_i);
		banks_closed_i <= 1'b0;
		if (lead)
			ctl.send(capc_cmd_t'(~c), 1'b0);
		ctl.send(c, 1'b1);
		#1;
		chk("alert", 1'b0, alert_n_o);
		chk("status", 1'b1, par_status_o);
		chk("quiet", 1'b1, dqs_quiet_o);
		chk("log", {c, ~^{c.act_n, c.addr, c.bg, c.ba}},
			{log_act_n_o, log_addr_o, log_bg_o, log_ba_o, log_cid_o, log_par_o});
		for (int i = 2; i <= 130; i++)
		begin
			@(posedge mclk_i);
			if (i == 61)
				banks_closed_i <= 1'b1;
			#1;
			np += (prech_all_o === 1'b1);
			ne += (exec_valid_o === 1'b1);
			if (alert_n_o === 1'b1 && ra == 0)
				ra = i;
			if (dqs_quiet_o === 1'b0 && rq == 0)
				rq = i;
		end
		// No refresh traffic is modelled, so there is none to repeat here
		chk("precharge", 1, np);
		chk("dropped", 0, ne);
		chk("release", 62, ra);
		chk("resume", 1, rq >= 100 && rq <= 104);
		chk("status kept", 1'b1, par_status_o);
	endtask

	task automatic s_error();
		ctl.mrw(3'h0, 1'b0, 1'b0);
		ctl.mrw(3'h1, 1'b0, 1'b0);
		err_run(C1, 1'b1);
		cmd_ok(C2, 1'b1, 4);
		chk("status", 1'b1, par_status_o);
		ctl.mrw(3'h1, 1'b0, 1'b0);
		#1;
		chk("cleared", 1'b0, par_status_o);
		err_run(C2, 1'b0);
	endtask

	// Persistent mode: the second error is caught with the status still set
	task automatic s_persist();
		ctl.mrw(3'h0, 1'b0, 1'b0);
		ctl.mrw(3'h1, 1'b0, 1'b1);
		err_run(C1, 1'b0);
		err_run(C2, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	initial
	begin
		repeat (3000) @(posedge mclk_i);
		n_mismatch++;
		report_and_stop();
	end

	initial
	begin
		{reset_i, banks_closed_i} = 2'h3;
		n_mismatch = 0;
		checks_done = 0;
		repeat (10) @(posedge mclk_i);
		reset_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		chk("reset", 5'h10, {alert_n_o, par_status_o, dqs_quiet_o, prech_all_o, exec_valid_o});
		s_latency();
		s_error();
		s_persist();
		report_and_stop();
	end
endmodule
